// [logic/eph_host.sv]
// Host controller that writes and reads a byte-wide page EEPROM over its pins.
// Assumes pins are synchronous to sys_clk and the device honours its timing.
// Function
// - Host keeps one fixed address for every toggle status read.
// - Host keeps page select lines constant for all bytes of one page.
// - Without polling or ready, host waits 10 ms after a write.
// - With polling or ready, host may access 150 ns after write start.
// - Page holds 1 to 128 bytes; next load within 30 us.
`timescale 1ns/10ps
module eph_host
   import eph_pkg::*;
#(
   parameter int WC_CYCLES = `EPH_WC_CYC,
   parameter int PAGE_BYTES = `EPH_PAGE_BYTES
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic cmd_valid,
   input wire eph_cmd_t cmd,
   output logic cmd_ready,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic page_error,
   output logic busy,
   output logic [`EPH_ADDR_W-1:0] mem_addr,
   output eph_strobe_t mem_strobe,
   input wire logic [7:0] mem_data_in,
   output logic [7:0] mem_data_out,
   output logic mem_data_oe,
   input wire logic ready_busy_n
);
   localparam int TW = $clog2(WC_CYCLES + 1);
   localparam int PW = $clog2(PAGE_BYTES + 1);
   // The load window has its own width so that a short simulated write time cannot truncate it.
   localparam int BW = $clog2(`EPH_BLC_CYC + 1);

   initial begin
      if (PAGE_BYTES < 1 || PAGE_BYTES > `EPH_PAGE_BYTES) $error("eph_host PAGE_BYTES out of range");
      if (WC_CYCLES < `EPH_DW_CYC) $error("eph_host WC_CYCLES below write start delay");
   end

   typedef enum logic [3:0] {
      ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_LOAD_WAIT, ST_START, ST_WAIT_TIMED,
      ST_POLL_LOW, ST_POLL_EVAL, ST_RD_LOW, ST_RD_DONE
   } eph_state_t;

   eph_state_t state_q;
   eph_cmd_t cmd_q;
   logic [`EPH_ADDR_W-1:0] page_base_q;
   logic [PW-1:0] count_q;
   logic prev_toggle_q;
   logic have_prev_q;
   logic tmr_load;
   logic [TW-1:0] tmr_value;
   logic tmr_done;
   logic [BW-1:0] blc_q;
   logic page_match;

   eph_timer #(.WIDTH(TW)) u_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .load(tmr_load),
      .value(tmr_value),
      .done(tmr_done)
   );

   assign page_match = (cmd.addr[`EPH_ADDR_W-1:`EPH_PAGE_LSB] == page_base_q[`EPH_ADDR_W-1:`EPH_PAGE_LSB]);
   // Commands are taken in idle, or while a page is still open for more bytes.
   assign cmd_ready = (state_q == ST_IDLE) || (state_q == ST_LOAD_WAIT);
   assign busy = (state_q != ST_IDLE) && (state_q != ST_LOAD_WAIT);

   // ---------------------------------------------------------------
   // Timer loads
   // ---------------------------------------------------------------
   // The shared timer times strobes, the write start delay and the full write time.
   always_comb begin
      tmr_load = 1'b0;
      tmr_value = '0;
      if (clk_en) begin
         unique case (state_q)
            ST_IDLE, ST_LOAD_WAIT: begin
               if (cmd_valid) begin
                  tmr_load = 1'b1;
                  tmr_value = TW'(`EPH_STROBE_CYC);
               end
            end
            ST_START: begin
               tmr_load = 1'b1;
               if (cmd_q.wait_mode == EPH_WAIT_TIMED) begin
                  tmr_value = TW'(WC_CYCLES);
               end else begin
                  tmr_value = TW'(`EPH_DW_CYC);
               end
            end
            ST_POLL_EVAL: begin
               tmr_load = 1'b1;
               tmr_value = TW'(`EPH_ACC_CYC);
            end
            default: begin
               tmr_load = 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Ending the page early on last avoids leaning on the device's idle auto-start.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         cmd_q <= '0;
         page_base_q <= '0;
         count_q <= '0;
         page_error <= 1'b0;
      end else if (clk_en) begin
         unique case (state_q)
            ST_IDLE, ST_LOAD_WAIT: begin
               if (cmd_valid) begin
                  page_error <= 1'b0;
                  if (state_q == ST_LOAD_WAIT && (!cmd.write || !page_match)) begin
                     // Reject a read or foreign page mid-page: drop the command and close the page.
                     page_error <= 1'b1;
                     state_q <= ST_START;
                  end else begin
                     cmd_q <= cmd;
                     if (state_q == ST_IDLE) begin
                        page_base_q <= cmd.addr;
                        count_q <= PW'(1);
                     end else begin
                        count_q <= count_q + 1'b1;
                     end
                     state_q <= cmd.write ? ST_WR_LOW : ST_RD_LOW;
                  end
               end else if (state_q == ST_LOAD_WAIT && blc_q == '0) begin
                  state_q <= ST_START;
               end
            end
            ST_WR_LOW: begin
               if (tmr_done) state_q <= ST_WR_HIGH;
            end
            ST_WR_HIGH: begin
               // Page full or last byte closes the page.
               if (cmd_q.last || count_q == PW'(PAGE_BYTES)) begin
                  state_q <= ST_START;
               end else begin
                  state_q <= ST_LOAD_WAIT;
               end
            end
            ST_START: begin
               state_q <= ST_WAIT_TIMED;
            end
            ST_WAIT_TIMED: begin
               if (tmr_done) begin
                  // Status modes pass through evaluate, which loads the access time for each read.
                  if (cmd_q.wait_mode == EPH_WAIT_TIMED) state_q <= ST_IDLE;
                  else state_q <= ST_POLL_EVAL;
               end
            end
            ST_POLL_EVAL: begin
               if (cmd_q.wait_mode == EPH_WAIT_READY) begin
                  if (ready_busy_n) state_q <= ST_IDLE;
               end else begin
                  state_q <= ST_POLL_LOW;
               end
            end
            ST_POLL_LOW: begin
               if (tmr_done) state_q <= ST_RD_DONE;
            end
            ST_RD_LOW: begin
               if (tmr_done) state_q <= ST_RD_DONE;
            end
            ST_RD_DONE: begin
               if (cmd_q.write) begin
                  if (cmd_q.wait_mode == EPH_WAIT_POLL &&
                      mem_data_in[`EPH_POLL_BIT] == cmd_q.data[`EPH_POLL_BIT]) begin
                     state_q <= ST_IDLE;
                  end else if (cmd_q.wait_mode == EPH_WAIT_TOGGLE && have_prev_q &&
                               mem_data_in[`EPH_TOGGLE_BIT] == prev_toggle_q) begin
                     state_q <= ST_IDLE;
                  end else begin
                     state_q <= ST_POLL_EVAL;
                  end
               end else begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Byte load window
   // ---------------------------------------------------------------
   // Counted from the edge that takes each load command, one cycle before its strobe falls; closes the page before 30 us.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         blc_q <= '0;
      end else if (clk_en) begin
         if (state_q != ST_WR_LOW && tmr_load && cmd_valid) begin
            blc_q <= BW'(`EPH_BLC_CYC - 2 * `EPH_STROBE_CYC);
         end else if (blc_q != '0) begin
            blc_q <= blc_q - 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Toggle tracking
   // ---------------------------------------------------------------
   // The first status read only records a level; the device starts it at 1.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         prev_toggle_q <= 1'b0;
         have_prev_q <= 1'b0;
      end else if (clk_en) begin
         if (state_q == ST_START) begin
            have_prev_q <= 1'b0;
         end else if (state_q == ST_RD_DONE && cmd_q.write) begin
            prev_toggle_q <= mem_data_in[`EPH_TOGGLE_BIT];
            have_prev_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin drive and read data
   // ---------------------------------------------------------------
   // Status reads reuse the last written address so the location stays fixed.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mem_addr <= '0;
         mem_strobe <= 3'b111;
         mem_data_out <= '0;
         mem_data_oe <= 1'b0;
         rd_data <= '0;
         rd_valid <= 1'b0;
      end else if (clk_en) begin
         rd_valid <= 1'b0;
         mem_strobe <= 3'b111;
         mem_data_oe <= 1'b0;
         if (state_q == ST_WR_LOW) begin
            mem_addr <= cmd_q.addr;
            mem_data_out <= cmd_q.data;
            mem_data_oe <= 1'b1;
            mem_strobe.ce_n <= 1'b0;
            mem_strobe.we_n <= tmr_done;
         end else if (state_q == ST_RD_LOW || state_q == ST_POLL_LOW) begin
            mem_addr <= cmd_q.addr;
            mem_strobe.ce_n <= 1'b0;
            mem_strobe.oe_n <= 1'b0;
         end else if (state_q == ST_RD_DONE && !cmd_q.write) begin
            rd_data <= mem_data_in;
            rd_valid <= 1'b1;
         end
      end
   end
endmodule

// [pkg/eph_defines.svh]
// Timing counts and field positions for the page EEPROM host controller.
// Assumes the includer runs on a 40 MHz clock; counts are derived from that rate.
`ifndef EPH_DEFINES_SVH
`define EPH_DEFINES_SVH

`define EPH_CLK_PERIOD_PS 25000
// Time figures in their own units.
`define EPH_WRITE_CYCLE_TIME_MS 10
`define EPH_WRITE_START_DELAY_NS 150
`define EPH_BYTE_LOAD_MAX_US 30
`define EPH_STROBE_WIDTH_NS 250
`define EPH_ACCESS_NS 150
// Derived cycle counts: least times round up, longest round down.
// The write cycle is reckoned in nanoseconds so that the product stays inside 32 bits.
`define EPH_WC_CYC ((`EPH_WRITE_CYCLE_TIME_MS * 1000000 + `EPH_CLK_PERIOD_PS / 1000 - 1) / (`EPH_CLK_PERIOD_PS / 1000))
`define EPH_DW_CYC ((`EPH_WRITE_START_DELAY_NS * 1000 + `EPH_CLK_PERIOD_PS - 1) / `EPH_CLK_PERIOD_PS)
`define EPH_BLC_CYC ((`EPH_BYTE_LOAD_MAX_US * 1000000) / `EPH_CLK_PERIOD_PS)
`define EPH_STROBE_CYC ((`EPH_STROBE_WIDTH_NS * 1000 + `EPH_CLK_PERIOD_PS - 1) / `EPH_CLK_PERIOD_PS)
`define EPH_ACC_CYC ((`EPH_ACCESS_NS * 1000 + `EPH_CLK_PERIOD_PS - 1) / `EPH_CLK_PERIOD_PS)
// Status bit positions on the data bus.
`define EPH_TOGGLE_BIT 6
`define EPH_POLL_BIT 7
// Page size and the lowest page-select address bit.
`define EPH_PAGE_BYTES 128
`define EPH_PAGE_LSB 7
`define EPH_ADDR_W 17

`endif

// [pkg/eph_pkg.sv]
// Types shared by the page EEPROM host controller files.
// Assumes eph_defines.svh supplies the widths.
`include "eph_defines.svh"
package eph_pkg;
   // Completion check method chosen per write.
   typedef enum logic [1:0] {
      EPH_WAIT_TIMED,
      EPH_WAIT_TOGGLE,
      EPH_WAIT_POLL,
      EPH_WAIT_READY
   } eph_wait_t;

   // One user command.
   typedef struct packed {
      logic write;
      logic last;
      eph_wait_t wait_mode;
      logic [`EPH_ADDR_W-1:0] addr;
      logic [7:0] data;
   } eph_cmd_t;

   // Pin-side strobes, all active low.
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
   } eph_strobe_t;
endpackage

// [logic/eph_timer.sv]
// Down-counting delay timer used for strobe widths and write waits.
// Assumes a load pulse starts it; done is high while the count is zero.
`timescale 1ns/10ps
module eph_timer #(
   parameter int WIDTH = 20
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic load,
   input wire logic [WIDTH-1:0] value,
   output logic done
);
   logic [WIDTH-1:0] cnt_q;

   initial begin
      if (WIDTH < 2) $error("eph_timer WIDTH too small");
   end

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   // A load wins over counting so a restart is never missed.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (clk_en) begin
         if (load) begin
            cnt_q <= value;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   assign done = (cnt_q == '0);
endmodule

// [testbench/eph_host_chk_sva.sv]
// Pin-level checker for the page EEPROM host.
// Assumes it is bound onto eph_host.
`timescale 1ns/10ps
`include "eph_defines.svh"
module eph_host_chk
   import eph_pkg::*;
#(parameter int WC_CYCLES = 200) (
   input logic sys_clk,
   input logic reset,
   input logic clk_en,
   input logic cmd_valid,
   input eph_cmd_t cmd,
   input logic cmd_ready,
   input logic rd_valid,
   input logic page_error,
   input logic busy,
   input logic [`EPH_ADDR_W-1:0] mem_addr,
   input eph_strobe_t mem_strobe,
   input logic mem_data_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic take, rtake, pend_q, timed_q;
   int idle_q;
   assign take = clk_en && cmd_valid && cmd_ready;
   assign rtake = take && !cmd.write;
   // Cycles since the write strobe rose, saturating to stay small.
   always_ff @(posedge sys_clk) begin
      if (reset || !mem_strobe.we_n) idle_q <= 0;
      else if (idle_q < WC_CYCLES) idle_q <= idle_q + 1;
   end
   // Remembers a timed final write until the next access starts.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pend_q <= 1'b0;
         timed_q <= 1'b0;
      end else begin
         if (take) pend_q <= cmd.write && cmd.last && cmd.wait_mode == EPH_WAIT_TIMED;
         if (!mem_strobe.we_n) timed_q <= pend_q;
         else if ($fell(mem_strobe.ce_n)) timed_q <= 1'b0;
      end
   end
   reset_idle_a: assert property ($fell(reset) |-> mem_strobe == 3'b111 && !mem_data_oe)
      else $error("pins not idle after reset");
   no_fight_a: assert property (mem_data_oe |-> mem_strobe.oe_n)
      else $error("bus driven during read");
   rd_lat_a: assert property (rd_valid |-> $past(rtake, 13))
      else $error("read answer late or stray");
   rd_pulse_a: assert property (rd_valid |=> !rd_valid)
      else $error("read pulse too long");
   write_gap_a: assert property ($rose(mem_strobe.we_n) ##1 busy |-> (!$fell(mem_strobe.ce_n))[*6])
      else $error("access too soon after write");
   timed_wait_a: assert property ($fell(mem_strobe.ce_n) && timed_q |-> idle_q >= WC_CYCLES - 1)
      else $error("timed wait too short");
   poll_addr_a: assert property (busy && !mem_strobe.oe_n && !$past(mem_strobe.oe_n) |-> $stable(mem_addr))
      else $error("status address moved");
   err_hold_a: assert property (page_error && !take |=> page_error)
      else $error("error flag dropped");
   we_width_a: assert property ($fell(mem_strobe.we_n) |-> (!mem_strobe.we_n)[*8])
      else $error("write strobe too short");
   cover property (take && cmd.write);
   cover property ($rose(page_error));
   cover property (rd_valid);
endmodule
bind eph_host eph_host_chk #(.WC_CYCLES(WC_CYCLES)) eph_host_chk_inst (.sys_clk(sys_clk), .reset(reset),
   .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
   .page_error(page_error), .busy(busy), .mem_addr(mem_addr), .mem_strobe(mem_strobe),
   .mem_data_oe(mem_data_oe));

// [testbench/eph_mem_model.sv]
// Behavioural page EEPROM seen at its pins.
// Assumes the bench resolves the data bus and pulls ready/busy up.
`timescale 1ns/10ps
module eph_mem_model
   import eph_pkg::*;
#(parameter int BL_CYC = 40, parameter int PROG_CYC = 60) (
   input logic sys_clk,
   input logic [16:0] mem_addr,
   input eph_strobe_t mem_strobe,
   input logic [7:0] mem_data_out,
   output logic [7:0] dev_q,
   output logic rb_low
);
   logic [7:0] mem [int];
   int pa[$];
   logic [7:0] pd[$];
   logic we_q = 1'b1;
   logic oe_q = 1'b1;
   logic tog_q;
   logic [7:0] last_q;
   int idle_q = 0;
   initial dev_q = 8'h5A;
   initial rb_low = 1'b0;
   // Shortened windows keep the run short; the total stays inside the host's wait.
   always @(posedge sys_clk) begin
      we_q <= mem_strobe.we_n;
      oe_q <= mem_strobe.oe_n | mem_strobe.ce_n;
      if (mem_strobe.we_n && !we_q) begin
         pa.push_back(mem_addr);
         pd.push_back(mem_data_out);
         last_q <= mem_data_out;
         tog_q <= 1'b1;
         rb_low <= 1'b1;
         idle_q <= 0;
      end else if (rb_low) begin
         idle_q <= idle_q + 1;
         if (idle_q == BL_CYC + PROG_CYC) begin
            foreach (pa[i]) mem[pa[i]] = pd[i];
            pa.delete();
            pd.delete();
            rb_low <= 1'b0;
         end
      end
      if (!(mem_strobe.oe_n | mem_strobe.ce_n) && oe_q) begin
         if (rb_low) begin
            dev_q <= {~last_q[7], tog_q, last_q[5:0]};
            tog_q <= ~tog_q;
         end else dev_q <= mem.exists(mem_addr) ? mem[mem_addr] : 8'hFF;
      end else if (oe_q) dev_q <= ~dev_q;
   end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the page EEPROM host with a pin model.
// Assumes the checker binds itself onto eph_host.
`timescale 1ns/10ps
module tb;
   import eph_pkg::*;
   localparam int WC = 200;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid = 1'b0;
   eph_cmd_t cmd = '0;
   logic cmd_ready, rd_valid, page_error, busy, mem_data_oe, rb_low;
   logic [7:0] rd_data, mem_data_out, dev_q, mem_data_in;
   logic [16:0] mem_addr;
   eph_strobe_t mem_strobe;
   logic [7:0] ref_m [int];
   int miscompares = 0;
   int checks = 0;
   int seed = 32'hd11404ca;
   int cyc = 0;
   assign mem_data_in = mem_data_oe ? mem_data_out : dev_q;
   always #12.5 sys_clk = ~sys_clk;
   eph_host #(.WC_CYCLES(WC)) eph_host_inst (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .page_error(page_error), .busy(busy), .mem_addr(mem_addr), .mem_strobe(mem_strobe),
      .mem_data_in(mem_data_in), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
      .ready_busy_n(!rb_low));
   eph_mem_model eph_mem_model_inst (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_strobe(mem_strobe),
      .mem_data_out(mem_data_out), .dev_q(dev_q), .rb_low(rb_low));
   // Cuts a hang short.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] exp_of(input int a);
      return ref_m.exists(a) ? ref_m[a] : 8'hFF;
   endfunction
   // Holds the command until the edge that takes it.
   task automatic issue(input logic w, input logic l, input eph_wait_t m, input logic [16:0] a,
                        input logic [7:0] d);
      @(negedge sys_clk);
      cmd = '{w, l, m, a, d};
      cmd_valid = 1'b1;
      while (!cmd_ready) @(negedge sys_clk);
      @(negedge sys_clk);
      cmd_valid = 1'b0;
   endtask
   task automatic rd(input logic [16:0] a);
      issue(1'b0, 1'b0, EPH_WAIT_TIMED, a, 8'h00);
      while (!rd_valid) @(negedge sys_clk);
      chk(rd_data, exp_of(a));
   endtask
   initial begin
      logic [16:0] a;
      logic [7:0] d;
      repeat (10) @(negedge sys_clk);
      reset = 1'b0;
      // One single-byte write per completion method, each read back.
      for (int m = 0; m < 4; m++) begin
         a = 17'($random(seed));
         d = 8'($random(seed));
         issue(1'b1, 1'b1, eph_wait_t'(m), a, d);
         ref_m[a] = d;
         chk({7'h00, busy}, 8'h01);
         rd(a);
      end
      // A full page closes itself at its last byte.
      a = 17'($random(seed));
      a[6:0] = 7'h00;
      for (int i = 0; i < 128; i++) begin
         d = 8'($random(seed));
         issue(1'b1, 1'b0, EPH_WAIT_TOGGLE, a + 17'(i), d);
         ref_m[a + i] = d;
      end
      for (int i = 0; i < 128; i += 37) rd(a + 17'(i));
      // A read or another page while a page is open is refused.
      for (int k = 0; k < 2; k++) begin
         a = 17'($random(seed));
         d = 8'($random(seed));
         issue(1'b1, 1'b0, EPH_WAIT_POLL, a, d);
         ref_m[a] = d;
         issue(k[0], 1'b1, EPH_WAIT_READY, a ^ 17'h00080, 8'h3C);
         repeat (2) @(negedge sys_clk);
         chk({7'h00, page_error}, 8'h01);
         rd(a);
         chk({7'h00, page_error}, 8'h00);
      end
      // An open page left alone is closed before the load window ends.
      a = 17'($random(seed));
      d = 8'($random(seed));
      issue(1'b1, 1'b0, EPH_WAIT_TOGGLE, a, d);
      ref_m[a] = d;
      repeat (1300) @(negedge sys_clk);
      rd(a);
      chk({7'h00, page_error}, 8'h00);
      report_and_stop();
   end
endmodule
